// File: serial_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: a tx buffer refill drops empty for one cycle
module serial_chan_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] load,
  output var  logic [3:0] tx_empty
);
  logic [3:0] sent_q;
  always_ff @(posedge clk) begin
    sent_q <= sys_rst ? 4'h0 : load;
    tx_empty <= sys_rst ? 4'hF : (tx_empty & ~load) | sent_q;
  end
endmodule
`default_nettype wire

// File: serial_irq_flag_enable.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module serial_irq_flag_enable
  import serial_irq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [NUM_CH-1:0] tx_empty,
  input  wire logic [NUM_CH-1:0] rx_done,
  input  wire logic [NUM_CH-1:0] rx_buf_read,
  input  wire logic [NUM_CH-1:0] tx_buf_write,
  output logic [NUM_CH-1:0]      rx_err_clear,
  output logic [NUM_FLAGS-1:0]   irq_req,
  output logic                   irq
);

  // channel index: 0 async0, 1 i2c0, 2 async1, 3 i2c1
  function automatic int unsigned rx_bit(input int unsigned ch);
    return (ch / 2) * PAIR_BITS + ((ch % 2 == 1) ? BIT_I2C_RX : BIT_ASYNC_RX);
  endfunction

  function automatic int unsigned tx_bit(input int unsigned ch);
    return (ch / 2) * PAIR_BITS + ((ch % 2 == 1) ? BIT_I2C_TX : BIT_ASYNC_TX);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs[ADDR_W-1:0];
  endfunction

  // flag storage
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;
  logic [NUM_FLAGS-1:0] flag_base;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [3:0]           flags_hi_q;
  logic [3:0]           flags_hi_d;

  // enable storage
  logic [NUM_FLAGS-1:0] enable_q;
  logic [NUM_FLAGS-1:0] enable_d;
  logic [3:0]           enable_hi_q;
  logic [3:0]           enable_hi_d;

  // event status and mask
  logic [7:0]           status_q;
  logic [7:0]           status_d;
  logic [7:0]           mask_q;
  logic [7:0]           mask_d;

  // read data
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;

  // input history
  logic [NUM_CH-1:0]    tx_empty_q;
  logic [NUM_CH-1:0]    tx_empty_d;
  logic [NUM_CH-1:0]    err_clear_q;
  logic [NUM_CH-1:0]    err_clear_d;

  // register access decode
  logic                 wr_flags0;
  logic                 wr_flags1;
  logic                 wr_enable0;
  logic                 wr_enable1;
  logic                 wr_mask;
  logic                 rd_status;

  // named flag views
  logic                 async_ch0_rx_flag;
  logic                 async_ch0_tx_flag;
  logic                 i2c_ch0_rx_flag;
  logic                 i2c_ch0_tx_flag;
  logic                 async_ch1_rx_flag;
  logic                 async_ch1_tx_flag;
  logic                 i2c_ch1_rx_flag;
  logic                 i2c_ch1_tx_flag;

  // named enable views
  logic                 async_ch0_rx_enable;
  logic                 async_ch0_tx_enable;
  logic                 i2c_ch0_rx_enable;
  logic                 i2c_ch0_tx_enable;
  logic                 async_ch1_rx_enable;
  logic                 async_ch1_tx_enable;
  logic                 i2c_ch1_rx_enable;
  logic                 i2c_ch1_tx_enable;

  // per-channel requests
  logic                 async_ch0_rx_req;
  logic                 async_ch0_tx_req;
  logic                 i2c_ch0_rx_req;
  logic                 i2c_ch0_tx_req;
  logic                 async_ch1_rx_req;
  logic                 async_ch1_tx_req;
  logic                 i2c_ch1_rx_req;
  logic                 i2c_ch1_tx_req;

  assign wr_flags0  = wr_stb & hit(addr, OFS_FLAGS_PAIR0);
  assign wr_flags1  = wr_stb & hit(addr, OFS_FLAGS_PAIR1);
  assign wr_enable0 = wr_stb & hit(addr, OFS_ENABLE_PAIR0);
  assign wr_enable1 = wr_stb & hit(addr, OFS_ENABLE_PAIR1);
  assign wr_mask    = wr_stb & hit(addr, OFS_EVENT_MASK);
  assign rd_status  = rd_stb & hit(addr, OFS_EVENT_STATUS);

  // hardware set and clear terms per flag
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      flag_set[rx_bit(c)] = rx_done[c];
      flag_set[tx_bit(c)] = tx_empty[c] & ~tx_empty_q[c];
      flag_clr[rx_bit(c)] = rx_buf_read[c];
      flag_clr[tx_bit(c)] = tx_buf_write[c];
    end
  end

  // flag group: software load, then hardware clears, then hardware sets
  always_comb begin
    flag_base  = flags_q;
    flags_hi_d = flags_hi_q;
    if (wr_flags0) begin
      flag_base[PAIR_BITS-1:0] = wdata[3:0];
    end
    if (wr_flags1) begin
      flag_base[NUM_FLAGS-1:PAIR_BITS] = wdata[3:0];
      flags_hi_d                       = wdata[7:4];
    end
    // a set in the same cycle as a clear wins
    flags_d = (flag_base & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q    <= {RST_FLAGS_NIBBLE, RST_FLAGS_NIBBLE};
      flags_hi_q <= RST_UNUSED_NIBBLE;
    end else begin
      flags_q    <= flags_d;
      flags_hi_q <= flags_hi_d;
    end
  end

  // enable group
  always_comb begin
    enable_d    = enable_q;
    enable_hi_d = enable_hi_q;
    if (wr_enable0) begin
      enable_d[PAIR_BITS-1:0] = wdata[3:0];
    end
    if (wr_enable1) begin
      enable_d[NUM_FLAGS-1:PAIR_BITS] = wdata[3:0];
      enable_hi_d                     = wdata[7:4];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q    <= {RST_ENABLE_NIBBLE, RST_ENABLE_NIBBLE};
      enable_hi_q <= RST_UNUSED_NIBBLE;
    end else begin
      enable_q    <= enable_d;
      enable_hi_q <= enable_hi_d;
    end
  end

  // event group: sticky status cleared by its read, and its mask
  always_comb begin
    status_d = status_q;
    mask_d   = mask_q;
    if (rd_status) begin
      status_d = '0;
    end
    if (wr_mask) begin
      mask_d = wdata;
    end
    // an event in the cycle of the clearing read is kept
    status_d = status_d | flag_set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= RST_EVENT_STATUS;
      mask_q   <= RST_EVENT_MASK;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (rd_stb) begin
      case (addr)
        OFS_ENABLE_PAIR0[ADDR_W-1:0]: begin
          rdata_d = {4'h0, enable_q[PAIR_BITS-1:0]};
        end
        OFS_FLAGS_PAIR0[ADDR_W-1:0]: begin
          rdata_d = {4'h0, flags_q[PAIR_BITS-1:0]};
        end
        OFS_ENABLE_PAIR1[ADDR_W-1:0]: begin
          rdata_d = {enable_hi_q, enable_q[NUM_FLAGS-1:PAIR_BITS]};
        end
        OFS_FLAGS_PAIR1[ADDR_W-1:0]: begin
          rdata_d = {flags_hi_q, flags_q[NUM_FLAGS-1:PAIR_BITS]};
        end
        OFS_EVENT_STATUS[ADDR_W-1:0]: begin
          rdata_d = status_q;
        end
        OFS_EVENT_MASK[ADDR_W-1:0]: begin
          rdata_d = mask_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // history group: tx empty level for edge detection, rx error clear pulse
  always_comb begin
    tx_empty_d  = tx_empty;
    err_clear_d = rx_buf_read;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_empty_q  <= RST_TX_EMPTY;
      err_clear_q <= RST_ERR_CLEAR;
    end else begin
      tx_empty_q  <= tx_empty_d;
      err_clear_q <= err_clear_d;
    end
  end

  // flag views, pair0 nibble then pair1 nibble
  assign async_ch0_rx_flag   = flags_q[BIT_ASYNC_RX];
  assign async_ch0_tx_flag   = flags_q[BIT_ASYNC_TX];
  assign i2c_ch0_rx_flag     = flags_q[BIT_I2C_RX];
  assign i2c_ch0_tx_flag     = flags_q[BIT_I2C_TX];
  assign async_ch1_rx_flag   = flags_q[PAIR_BITS + BIT_ASYNC_RX];
  assign async_ch1_tx_flag   = flags_q[PAIR_BITS + BIT_ASYNC_TX];
  assign i2c_ch1_rx_flag     = flags_q[PAIR_BITS + BIT_I2C_RX];
  assign i2c_ch1_tx_flag     = flags_q[PAIR_BITS + BIT_I2C_TX];

  // enable views, pair0 nibble then pair1 nibble
  assign async_ch0_rx_enable = enable_q[BIT_ASYNC_RX];
  assign async_ch0_tx_enable = enable_q[BIT_ASYNC_TX];
  assign i2c_ch0_rx_enable   = enable_q[BIT_I2C_RX];
  assign i2c_ch0_tx_enable   = enable_q[BIT_I2C_TX];
  assign async_ch1_rx_enable = enable_q[PAIR_BITS + BIT_ASYNC_RX];
  assign async_ch1_tx_enable = enable_q[PAIR_BITS + BIT_ASYNC_TX];
  assign i2c_ch1_rx_enable   = enable_q[PAIR_BITS + BIT_I2C_RX];
  assign i2c_ch1_tx_enable   = enable_q[PAIR_BITS + BIT_I2C_TX];

  // a channel requests only while its flag and its enable are both set
  assign async_ch0_rx_req    = async_ch0_rx_flag & async_ch0_rx_enable;
  assign async_ch0_tx_req    = async_ch0_tx_flag & async_ch0_tx_enable;
  assign i2c_ch0_rx_req      = i2c_ch0_rx_flag & i2c_ch0_rx_enable;
  assign i2c_ch0_tx_req      = i2c_ch0_tx_flag & i2c_ch0_tx_enable;
  assign async_ch1_rx_req    = async_ch1_rx_flag & async_ch1_rx_enable;
  assign async_ch1_tx_req    = async_ch1_tx_flag & async_ch1_tx_enable;
  assign i2c_ch1_rx_req      = i2c_ch1_rx_flag & i2c_ch1_rx_enable;
  assign i2c_ch1_tx_req      = i2c_ch1_tx_flag & i2c_ch1_tx_enable;

  assign irq_req = {i2c_ch1_tx_req, i2c_ch1_rx_req, async_ch1_tx_req, async_ch1_rx_req,
                    i2c_ch0_tx_req, i2c_ch0_rx_req, async_ch0_tx_req, async_ch0_rx_req};

  // level interrupt from unmasked sticky status
  assign irq = |(status_q & mask_q);

  // registered outputs
  assign rdata        = rdata_q;
  assign rx_err_clear = err_clear_q;

endmodule

`default_nettype wire

// File: serial_irq_flag_enable_checker.sv
`timescale 1ns/1ps
`default_nettype none
module irq_bank_checker
  import serial_irq_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [3:0] tx_empty,
  input wire logic [3:0] rx_done,
  input wire logic [3:0] rx_buf_read,
  input wire logic [3:0] tx_buf_write,
  input wire logic [3:0] rx_err_clear,
  input wire logic [7:0] irq_req,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  err_clear_a: assert property (rx_buf_read[1] |=> rx_err_clear[1])
    else $error("rx error clear missing");
  rx_drop_a: assert property (rx_buf_read[0] && !rx_done[0] && !wr_stb |=> !irq_req[0])
    else $error("rx request not cleared");
  tx_drop_a: assert property (tx_buf_write[1] && $stable(tx_empty[1]) && !wr_stb
    |=> !irq_req[3]) else $error("tx request not cleared");
  rx_rise_a: assert property ($rose(irq_req[4]) |-> $past(rx_done[2] || wr_stb))
    else $error("rx request without cause");
  tx_rise_a: assert property ($rose(irq_req[3]) |-> $past(wr_stb)
    || $past(tx_empty[1]) && !$past(tx_empty[1], 2)) else $error("tx request without cause");
  hi_nibble_a: assert property (rd_stb && addr == OFS_FLAGS_PAIR0 |=> rdata[7:4] == 4'h0)
    else $error("pair0 upper flags driven");
  rd_idle_a: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata not idle");
  irq_rise_a: assert property ($rose(irq) |-> $past(wr_stb || |rx_done || |tx_empty))
    else $error("irq without cause");
endmodule
`default_nettype wire

// File: serial_irq_pkg.sv
package serial_irq_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned NUM_FLAGS  = 8;

  // register offsets
  localparam logic [7:0] OFS_ENABLE_PAIR0 = 8'h01;
  localparam logic [7:0] OFS_FLAGS_PAIR0  = 8'h03;
  localparam logic [7:0] OFS_ENABLE_PAIR1 = 8'h06;
  localparam logic [7:0] OFS_FLAGS_PAIR1  = 8'h07;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT_MASK   = 8'h09;

  // field positions inside a channel pair nibble
  localparam int unsigned BIT_ASYNC_RX = 0;
  localparam int unsigned BIT_ASYNC_TX = 1;
  localparam int unsigned BIT_I2C_RX   = 2;
  localparam int unsigned BIT_I2C_TX   = 3;
  localparam int unsigned PAIR_BITS    = 4;

  // values after reset
  localparam logic [3:0] RST_FLAGS_NIBBLE  = 4'hA;
  localparam logic [3:0] RST_ENABLE_NIBBLE = 4'h0;
  localparam logic [3:0] RST_UNUSED_NIBBLE = 4'h0;
  localparam logic [7:0] RST_EVENT_STATUS  = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK    = 8'h00;
  localparam logic [7:0] RST_RDATA         = 8'h00;
  localparam logic [3:0] RST_TX_EMPTY      = 4'hF;
  localparam logic [3:0] RST_ERR_CLEAR     = 4'h0;

endpackage

// File: test_serial_irq_flag_enable.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_irq_flag_enable;
  logic       clk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, irq_req;
  logic [3:0] tx_empty, rx_done = 4'h0, rx_buf_read = 4'h0, load = 4'h0, rx_err_clear;
  logic [7:0] ofs [7] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h55};
  logic [7:0] rst_v [7] = '{8'h00, 8'h0A, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00};
  int         miscompares = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  serial_irq_flag_enable DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_empty(tx_empty), .rx_done(rx_done),
    .rx_buf_read(rx_buf_read), .tx_buf_write(load), .rx_err_clear(rx_err_clear),
    .irq_req(irq_req), .irq(irq));
  serial_chan_model peer (.clk(clk), .sys_rst(sys_rst), .load(load), .tx_empty(tx_empty));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], rst_v[i]);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'hFF);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h0F);
    wr(8'h07, 8'hF0);
    wr(8'h03, 8'hFF);
    wr(8'h03, 8'h00);
    rd(8'h07, 8'hF0);
    chk("irq_req", 8'h00, irq_req);
    @(posedge clk);
    rx_done <= 4'hF;
    @(posedge clk);
    rx_done <= 4'h0;
    #1 chk("irq_req", 8'h55, irq_req);
    wr(8'h06, 8'h0E);
    #1 chk("irq_req", 8'h45, irq_req);
    wr(8'h06, 8'hFF);
    rd(8'h03, 8'h05);
    rd(8'h07, 8'hF5);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hFF);
    chk("irq", 8'h01, {7'h0, irq});
    rd(8'h08, 8'h55);
    chk("irq", 8'h00, {7'h0, irq});
    @(posedge clk);
    rx_buf_read <= 4'hF;
    @(posedge clk);
    rx_buf_read <= 4'h0;
    #1 chk("irq_req", 8'h00, irq_req);
    chk("rx_err_clear", 8'h0F, {4'h0, rx_err_clear});
    @(posedge clk);
    load <= 4'hF;
    @(posedge clk);
    load <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk("irq_req", 8'hAA, irq_req);
    rd(8'h03, 8'h0A);
    rd(8'h08, 8'hAA);
    @(posedge clk);
    load <= 4'h2;
    @(posedge clk);
    load <= 4'h0;
    #1 chk("irq_req", 8'hA2, irq_req);
    end_of_test;
  end
endmodule
bind serial_irq_flag_enable irq_bank_checker watch (.clk(clk), .sys_rst(sys_rst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .tx_empty(tx_empty), .rx_done(rx_done), .rx_buf_read(rx_buf_read),
  .tx_buf_write(tx_buf_write), .rx_err_clear(rx_err_clear), .irq_req(irq_req), .irq(irq));
`default_nettype wire
